// ==== data_map_pkg.sv ====
package data_map_pkg;

  // ----------------------------------------------------------------
  // data space layout
  // ----------------------------------------------------------------
  localparam logic [15:0] RF_LIMIT     = 16'h0020;
  localparam logic [15:0] IO_LIMIT     = 16'h0060;
  localparam logic [15:0] SRAM_BASE    = 16'h0060;
  localparam logic [15:0] SRAM_TOP     = 16'h0FFF;
  localparam logic [6:0]  IO_DATA_BASE = 7'h20;
  localparam int          SRAM_BYTES   = 4000;
  localparam int          SRAM_AW      = 12;

  // ----------------------------------------------------------------
  // pointer pairs, low byte in the even register
  // ----------------------------------------------------------------
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [4:0] PTR_Z_HI = 5'h1F;
  localparam logic       IMM_HALF = 1'h1;

  // ----------------------------------------------------------------
  // i/o locations and control bits
  // ----------------------------------------------------------------
  localparam logic [5:0] IO_SP_LO       = 6'h3D;
  localparam logic [5:0] IO_SP_HI       = 6'h3E;
  localparam logic [5:0] IO_MCU_CTL     = 6'h35;
  localparam int         CTL_EXT_EN_BIT = 7;
  localparam int         CTL_WAIT_BIT   = 6;
  localparam logic [7:0] IO_RESET       = 8'h00;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam int         IRQ_LINES      = 8;
  localparam int         IRQ_VW         = 3;

  typedef enum logic [2:0] {
    AM_DIRECT, AM_DISP, AM_IND, AM_PREDEC, AM_POSTINC, AM_IO, AM_PUSH, AM_POP
  } addr_mode_e;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_e;

  typedef enum logic [2:0] {TGT_RF, TGT_IO, TGT_SRAM, TGT_EXT, TGT_NONE} tgt_e;

  typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_ALE, ST_DATA, ST_WAIT} mem_state_e;

  typedef struct packed {
    logic [4:0] rd_a_idx;
    logic [4:0] rd_b_idx;
    logic       imm_form;
    logic       wr_en;
    logic [4:0] wr_idx;
    logic [7:0] wr_data;
  } alu_req_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        pc_pair;
    addr_mode_e  mode;
    ptr_sel_e    ptr;
    logic [5:0]  disp;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [4:0]  dest;
    logic [15:0] pc;
  } mem_req_s;

  typedef struct packed {
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] addr_hi;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
  } ext_bus_s;

  localparam ext_bus_s BUS_IDLE = '{8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1};

endpackage

// ==== data_space_map_regfile.sv ====
`timescale 1ns/100ps
`default_nettype none

module data_space_map_regfile
  import data_map_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire alu_req_s             alu_req,
  output logic     [7:0]            op_a,
  output logic     [7:0]            op_b,
  input  wire mem_req_s             mem_req,
  output logic                      mem_busy,
  output logic                      mem_done,
  output logic     [7:0]            mem_rdata,
  output logic     [15:0]           ret_pc,
  input  wire logic                 fetch_adv,
  input  wire logic                 pc_load,
  input  wire logic [15:0]          pc_value,
  input  wire logic [15:0]          instr_word,
  output logic     [15:0]           program_counter,
  output logic     [15:0]           instr,
  output logic     [15:0]           const_byte_addr,
  input  wire logic [IRQ_LINES-1:0] irq_pend,
  output logic     [IRQ_LINES-1:0]  irq_grant,
  output logic     [IRQ_VW-1:0]     irq_vec,
  output logic     [15:0]           stack_ptr,
  input  wire logic [7:0]           ad_in,
  output ext_bus_s                  ext_bus
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sh_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sh_q <= 2'h0;
    end else begin
      rst_sh_q <= {rst_sh_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sh_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0][7:0]       rf;
    logic [63:0][7:0]       io;
    mem_state_e             st;
    tgt_e                   tgt;
    logic [15:0]            ea;
    logic [7:0]             wdata;
    logic                   write;
    logic                   pair;
    logic                   second;
    logic                   stack;
    logic                   pop;
    logic [4:0]             dest;
    logic [15:0]            pc_in;
    logic [7:0]             op_a;
    logic [7:0]             op_b;
    logic                   busy;
    logic                   done;
    logic [7:0]             rdata;
    logic [15:0]            ret_pc;
    ext_bus_s               bus;
    logic [15:0]            pc;
    logic [15:0]            instr;
    logic [15:0]            const_addr;
    logic [IRQ_LINES-1:0]   grant;
    logic [IRQ_VW-1:0]      vec;
  } state_s;

  state_s            s_q;
  state_s            s_d;
  logic [IRQ_LINES-1:0] irq_sync;
  logic [7:0]        sram_q;
  logic [7:0]        sram_mem [0:SRAM_BYTES-1];
  logic [SRAM_AW-1:0] sram_rd_idx;
  logic [SRAM_AW-1:0] sram_wr_idx;
  logic              sram_we;
  logic              ext_en;
  logic              wait_en;

  // interrupt lines may come straight from pins, so they are filtered before arbitration
  pin_sync3 #(.W(IRQ_LINES)) u_irq_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (irq_pend),
    .dout     (irq_sync)
  );

  assign ext_en  = s_q.io[IO_MCU_CTL][CTL_EXT_EN_BIT];
  assign wait_en = s_q.io[IO_MCU_CTL][CTL_WAIT_BIT];

  function automatic tgt_e decode(input logic [15:0] a, input logic en);
    if (a < RF_LIMIT) begin
      decode = TGT_RF;
    end else if (a < IO_LIMIT) begin
      decode = TGT_IO;
    end else if (a <= SRAM_TOP) begin
      decode = TGT_SRAM;
    end else if (en) begin
      decode = TGT_EXT;
    end else begin
      decode = TGT_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [4:0]  ia;
  logic [4:0]  wi;
  logic [4:0]  plo;
  logic [15:0] ptr;
  logic [15:0] sp;
  logic [15:0] lea;
  logic        launch;
  logic        fin;
  logic [7:0]  rd;
  logic [5:0]  iox;

  always_comb begin
    s_d    = s_q;
    ia     = alu_req.rd_a_idx;
    wi     = alu_req.wr_idx;
    plo    = PTR_X_LO;
    ptr    = 16'h0000;
    sp     = {s_q.io[IO_SP_HI], s_q.io[IO_SP_LO]};
    lea    = 16'h0000;
    launch = 1'b0;
    fin    = 1'b0;
    rd     = 8'h00;
    iox    = 6'h00;
    s_d.done = 1'b0;

    // constant-with-register forms see only the upper half for operand a and the write index; operand b is not remapped
    if (alu_req.imm_form) begin
      ia = {IMM_HALF, alu_req.rd_a_idx[3:0]};
      wi = {IMM_HALF, alu_req.wr_idx[3:0]};
    end
    if (alu_req.wr_en) begin
      s_d.rf[wi] = alu_req.wr_data;
    end
    s_d.op_a = s_d.rf[ia];
    s_d.op_b = s_d.rf[alu_req.rd_b_idx];

    if (pc_load) begin
      s_d.pc = pc_value;
    end else if (fetch_adv) begin
      s_d.instr = instr_word;
      s_d.pc    = s_q.pc + 16'h0001;
    end
    s_d.const_addr = {s_q.rf[PTR_Z_HI], s_q.rf[PTR_Z_LO]};

    s_d.grant = irq_sync & (~irq_sync + 1'b1);
    s_d.vec   = '0;
    for (int i = IRQ_LINES - 1; i >= 0; i--) begin
      if (irq_sync[i]) begin
        s_d.vec = IRQ_VW'(i);
      end
    end

    case (s_q.st)
      ST_IDLE: begin
        if (mem_req.valid) begin
          case (mem_req.ptr)
            PTR_Y:   plo = PTR_Y_LO;
            PTR_Z:   plo = PTR_Z_LO;
            default: plo = PTR_X_LO;
          endcase
          ptr = {s_q.rf[plo + 5'h01], s_q.rf[plo]};
          s_d.write  = mem_req.write;
          s_d.pair   = mem_req.pc_pair;
          s_d.second = 1'b0;
          s_d.stack  = (mem_req.mode == AM_PUSH) || (mem_req.mode == AM_POP);
          s_d.pop    = (mem_req.mode == AM_POP);
          s_d.dest   = mem_req.dest;
          s_d.pc_in  = mem_req.pc;
          s_d.wdata  = mem_req.pc_pair ? mem_req.pc[7:0] : mem_req.wdata;
          s_d.busy   = 1'b1;
          launch     = 1'b1;
          case (mem_req.mode)
            AM_DISP:    lea = ptr + {10'h000, mem_req.disp};
            AM_IND:     lea = ptr;
            AM_PREDEC:  lea = ptr - 16'h0001;
            AM_POSTINC: lea = ptr;
            AM_IO:      lea = {9'h000, IO_DATA_BASE} + {10'h000, mem_req.addr[5:0]};
            default:    lea = mem_req.addr;
          endcase
          if (mem_req.mode == AM_PREDEC) begin
            {s_d.rf[plo + 5'h01], s_d.rf[plo]} = ptr - 16'h0001;
          end else if (mem_req.mode == AM_POSTINC) begin
            {s_d.rf[plo + 5'h01], s_d.rf[plo]} = ptr + 16'h0001;
          end
        end
      end
      ST_INT: begin
        fin = 1'b1;
      end
      ST_ALE: begin
        s_d.bus.ale = 1'b0;
        if (s_q.write) begin
          s_d.bus.ad_out = s_q.wdata;
          s_d.bus.ad_oe  = 1'b1;
          s_d.bus.wr_n   = 1'b0;
        end else begin
          s_d.bus.ad_oe = 1'b0;
          s_d.bus.rd_n  = 1'b0;
        end
        s_d.st = ST_DATA;
      end
      ST_DATA: begin
        if (wait_en) begin
          s_d.st = ST_WAIT;
        end else begin
          fin = 1'b1;
        end
      end
      ST_WAIT: begin
        fin = 1'b1;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // byte finished: move data, then go again for a second pc byte
    if (fin) begin
      iox = 6'(s_q.ea[6:0] - IO_DATA_BASE);
      case (s_q.tgt)
        TGT_RF:   rd = s_q.rf[s_q.ea[4:0]];
        TGT_IO:   rd = s_q.io[iox];
        TGT_SRAM: rd = sram_q;
        // the sram answers our own registered strobes, so its data is on this clock;
        // a pin filter here would miss the read by several cycles
        TGT_EXT:  rd = ad_in;
        default:  rd = 8'h00;
      endcase
      if (s_q.write) begin
        if (s_q.tgt == TGT_RF) begin
          s_d.rf[s_q.ea[4:0]] = s_q.wdata;
        end else if (s_q.tgt == TGT_IO) begin
          s_d.io[iox] = s_q.wdata;
        end
      end else if (s_q.pair) begin
        if (s_q.second) begin
          s_d.ret_pc[7:0] = rd;
        end else begin
          s_d.ret_pc[15:8] = rd;
        end
      end else begin
        s_d.rf[s_q.dest] = rd;
        s_d.rdata        = rd;
      end
      s_d.bus.ad_oe = 1'b0;
      s_d.bus.rd_n  = 1'b1;
      s_d.bus.wr_n  = 1'b1;
      if (s_q.pair && !s_q.second) begin
        s_d.second = 1'b1;
        s_d.wdata  = s_q.pc_in[15:8];
        launch     = 1'b1;
      end else begin
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.st   = ST_IDLE;
      end
    end

    // stack steps use the pointer as it stands after any i/o write
    if (launch && s_d.stack) begin
      sp = {s_d.io[IO_SP_HI], s_d.io[IO_SP_LO]};
      if (s_d.pop) begin
        lea = sp + 16'h0001;
      end else begin
        lea = sp;
      end
      {s_d.io[IO_SP_HI], s_d.io[IO_SP_LO]} = s_d.pop ? sp + 16'h0001 : sp - 16'h0001;
    end

    if (launch) begin
      s_d.ea  = lea;
      s_d.tgt = decode(lea, ext_en);
      if (s_d.tgt == TGT_EXT) begin
        s_d.st          = ST_ALE;
        s_d.bus.ale     = 1'b1;
        s_d.bus.ad_out  = lea[7:0];
        s_d.bus.ad_oe   = 1'b1;
        s_d.bus.addr_hi = lea[15:8];
      end else begin
        s_d.st = ST_INT;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.io     <= {64{IO_RESET}};
      s_q.st     <= ST_IDLE;
      s_q.tgt    <= TGT_NONE;
      s_q.bus    <= BUS_IDLE;
      s_q.pc     <= PC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // internal data sram
  // ----------------------------------------------------------------
  // read is launched with the next address so data lands in ST_INT
  assign sram_rd_idx = SRAM_AW'(s_d.ea[SRAM_AW-1:0] - SRAM_BASE[SRAM_AW-1:0]);
  assign sram_wr_idx = SRAM_AW'(s_q.ea[SRAM_AW-1:0] - SRAM_BASE[SRAM_AW-1:0]);
  assign sram_we     = (s_q.st == ST_INT) && (s_q.tgt == TGT_SRAM) && s_q.write;

  always_ff @(posedge core_clk) begin
    if (sram_we && (sram_wr_idx < SRAM_AW'(SRAM_BYTES))) begin
      sram_mem[sram_wr_idx] <= s_q.wdata;
    end
    if (sram_rd_idx < SRAM_AW'(SRAM_BYTES)) begin
      sram_q <= sram_mem[sram_rd_idx];
    end else begin
      sram_q <= 8'h00;
    end
  end

  assign op_a            = s_q.op_a;
  assign op_b            = s_q.op_b;
  assign mem_busy        = s_q.busy;
  assign mem_done        = s_q.done;
  assign mem_rdata       = s_q.rdata;
  assign ret_pc          = s_q.ret_pc;
  assign program_counter = s_q.pc;
  assign instr           = s_q.instr;
  assign const_byte_addr = s_q.const_addr;
  assign irq_grant       = s_q.grant;
  assign irq_vec         = s_q.vec;
  assign stack_ptr       = {s_q.io[IO_SP_HI], s_q.io[IO_SP_LO]};
  assign ext_bus         = s_q.bus;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic start;
  logic start_int;
  logic start_ext;

  assign start     = (s_q.st == ST_IDLE) && mem_req.valid && !mem_req.pc_pair;
  assign start_int = start && (s_d.tgt != TGT_EXT);
  assign start_ext = start && (s_d.tgt == TGT_EXT);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_RF_FWD: assert property (
    alu_req.wr_en && !alu_req.imm_form && (alu_req.rd_b_idx == alu_req.wr_idx)
      && (s_q.st == ST_IDLE) && !mem_req.valid |=> op_b == $past(alu_req.wr_data))
    else $error("operand b missed same-cycle write-back");

  AST_IMM_UPPER: assert property (
    alu_req.imm_form && !alu_req.wr_en && (s_q.st == ST_IDLE) && !mem_req.valid
      |=> op_a == $past(s_q.rf[{IMM_HALF, alu_req.rd_a_idx[3:0]}]))
    else $error("immediate form read the lower half");

  AST_INT_TWO: assert property (
    start_int |-> ##1 !mem_done ##1 mem_done)
    else $error("internal access not done in two cycles");

  AST_EXT_NOWAIT: assert property (
    start_ext && !wait_en |-> ##1 !mem_done [*2] ##1 mem_done)
    else $error("external access without wait not three cycles");

  AST_EXT_WAIT: assert property (
    start_ext && wait_en |-> ##1 !mem_done [*3] ##1 mem_done)
    else $error("external access with wait not four cycles");

  AST_EXT_PAIR: assert property (
    (s_q.st == ST_IDLE) && mem_req.valid && mem_req.pc_pair && !wait_en
      && (s_d.tgt == TGT_EXT) && (decode(s_d.ea - 16'h0001, ext_en) == TGT_EXT)
      && mem_req.write |-> ##1 !mem_done [*4] ##1 mem_done)
    else $error("external pc push not five cycles");

  AST_STROBE_QUIET: assert property (
    mem_busy && (s_q.tgt != TGT_EXT) |-> ext_bus.rd_n && ext_bus.wr_n)
    else $error("strobe active during internal access");

  AST_ALE_ADDR: assert property (
    ext_bus.ale |-> ext_bus.ad_oe && (ext_bus.ad_out == s_q.ea[7:0]) ##1 !ext_bus.ale)
    else $error("latch strobe without low address");

  AST_IRQ_PRIO: assert property (
    |irq_sync |=> ((irq_grant & $past(irq_sync)) != '0)
      && (($past(irq_sync) & (irq_grant - 1'b1)) == '0))
    else $error("interrupt grant not lowest pending line");

  AST_CONST_Z: assert property (
    1'b1 |=> const_byte_addr == $past({s_q.rf[PTR_Z_HI], s_q.rf[PTR_Z_LO]}))
    else $error("constant address not taken from third pointer");

  COV_INT: cover property (start_int ##2 mem_done);
  COV_EXT_WAIT: cover property (start_ext && wait_en ##4 mem_done);
  COV_POP_PC: cover property (mem_req.valid && (mem_req.mode == AM_POP) && mem_req.pc_pair);
  COV_IRQ: cover property ($countones(irq_pend) > 1);

endmodule

`default_nettype wire

// ==== data_space_map_regfile_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module data_space_map_regfile_tb
  import data_map_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 reset_n = 1'b0;
  alu_req_s             alu_req = '0;
  mem_req_s             mem_req = '0;
  logic                 fetch_adv = 1'b0;
  logic                 pc_load = 1'b0;
  logic [15:0]          pc_value = 16'h0000;
  logic [15:0]          instr_word = 16'h0000;
  logic [IRQ_LINES-1:0] irq_pend = '0;
  logic [7:0]           op_a, op_b, mem_rdata, sram_dq;
  logic                 mem_busy, mem_done;
  logic [15:0]          ret_pc, program_counter, instr, const_byte_addr, stack_ptr;
  logic [IRQ_LINES-1:0] irq_grant;
  logic [IRQ_VW-1:0]    irq_vec;
  ext_bus_s             ext_bus;
  wire  [7:0]           ad_in = ext_bus.ad_oe ? ext_bus.ad_out : sram_dq;
  int                   num_errors = 0;
  int                   comparisons = 0;
  int                   n, strb, ale_n;
  logic [15:0]          ale_a;

  always #2 core_clk = ~core_clk;

  data_space_map_regfile dut (.core_clk, .reset_n, .alu_req, .op_a, .op_b, .mem_req,
    .mem_busy, .mem_done, .mem_rdata, .ret_pc, .fetch_adv, .pc_load, .pc_value, .instr_word,
    .program_counter, .instr, .const_byte_addr, .irq_pend, .irq_grant, .irq_vec,
    .stack_ptr, .ad_in, .ext_bus);
  ext_sram_model sram (.core_clk, .ext_bus, .dq(sram_dq));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic alu(input logic we, input logic [4:0] wi, input logic [7:0] wd,
                     input logic im, input logic [4:0] ri);
    @(posedge core_clk);
    alu_req <= '{ri, ri, im, we, wi, wd};
    @(posedge core_clk);
    alu_req.wr_en <= 1'b0;
    #1;
  endtask

  // counts cycles from the request cycle up to the one that shows done
  task automatic mem(input logic w, input addr_mode_e m, input ptr_sel_e p,
                     input logic [5:0] d, input logic [15:0] a, input logic [7:0] wd,
                     input logic pp);
    @(posedge core_clk);
    mem_req <= '{1'b1, w, pp, m, p, d, a, wd, 5'h00, 16'h1234};
    @(posedge core_clk);
    mem_req.valid <= 1'b0;
    n = 1;
    strb = 0;
    ale_n = 0;
    #1;
    chk({15'h0000, mem_busy}, 16'h0001);
    if (ext_bus.ale) begin
      ale_n++;
      ale_a = {ext_bus.addr_hi, ext_bus.ad_out};
    end
    do begin
      @(posedge core_clk);
      n++;
      #1;
      if (!ext_bus.rd_n || !ext_bus.wr_n) strb++;
      if (ext_bus.ale) begin
        ale_n++;
        ale_a = {ext_bus.addr_hi, ext_bus.ad_out};
      end
    end while (mem_done !== 1'b1 && n < 20);
    if (mem_done !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t access never finished", $time);
    end
  endtask

  task automatic io(input logic [5:0] a, input logic [7:0] d);
    mem(1'b1, AM_IO, PTR_X, 6'h00, {10'h000, a}, d, 1'b0);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mem(1'b1, AM_DIRECT, PTR_X, 6'h00, a, d, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a);
    mem(1'b0, AM_DIRECT, PTR_X, 6'h00, a, 8'h00, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alu();
    alu(1'b1, 5'h03, 8'h5A, 1'b1, 5'h03);
    chk(op_a, 16'h005A);
    chk(op_b, 16'h0000);
    alu(1'b1, 5'h03, 8'hC3, 1'b0, 5'h03);
    chk(op_a, 16'h00C3);
    chk(op_b, 16'h00C3);
    alu(1'b0, 5'h00, 8'h00, 1'b0, 5'h13);
    chk(op_a, 16'h005A);
    $display("alu test done");
  endtask

  task automatic t_map();
    wr(16'h0004, 8'h77);
    chk(16'(n), 16'd2);
    chk(16'(strb), 16'd0);
    chk(16'(mem_busy), 16'h0000);
    alu(1'b0, 5'h00, 8'h00, 1'b0, 5'h04);
    chk(op_a, 16'h0077);
    io(IO_SP_LO, 8'h00);
    io(IO_SP_HI, 8'h02);
    chk(stack_ptr, 16'h0200);
    rd(16'h005E);
    chk(mem_rdata, 16'h0002);
    wr(16'h0060, 8'h11);
    wr(16'h0FFF, 8'h22);
    rd(16'h0FFF);
    chk(mem_rdata, 16'h0022);
    chk(16'(strb), 16'd0);
    rd(16'h1000);
    chk(mem_rdata, 16'h0000);
    chk(16'(strb), 16'd0);
    $display("map test done");
  endtask

  task automatic t_ptr();
    alu(1'b1, 5'h1C, 8'h60, 1'b0, 5'h1C);
    alu(1'b1, 5'h1D, 8'h00, 1'b0, 5'h1D);
    mem(1'b0, AM_IND, PTR_Y, 6'h00, 16'h0000, 8'h00, 1'b0);
    chk(mem_rdata, 16'h0011);
    mem(1'b1, AM_DISP, PTR_Y, 6'h3F, 16'h0000, 8'h33, 1'b0);
    rd(16'h009F);
    chk(mem_rdata, 16'h0033);
    mem(1'b0, AM_POSTINC, PTR_Y, 6'h00, 16'h0000, 8'h00, 1'b0);
    alu(1'b0, 5'h00, 8'h00, 1'b0, 5'h1C);
    chk(op_a, 16'h0061);
    alu(1'b1, 5'h1A, 8'h00, 1'b0, 5'h1A);
    alu(1'b1, 5'h1B, 8'h01, 1'b0, 5'h1B);
    mem(1'b0, AM_PREDEC, PTR_X, 6'h00, 16'h0000, 8'h00, 1'b0);
    alu(1'b0, 5'h00, 8'h00, 1'b0, 5'h1A);
    chk(op_a, 16'h00FF);
    alu(1'b1, 5'h1E, 8'h34, 1'b0, 5'h1E);
    alu(1'b1, 5'h1F, 8'h12, 1'b0, 5'h1F);
    @(posedge core_clk);
    #1;
    chk(const_byte_addr, 16'h1234);
    $display("pointer test done");
  endtask

  task automatic t_ext();
    io(IO_MCU_CTL, 8'h80);
    wr(16'h1000, 8'hA5);
    chk(16'(n), 16'd3);
    chk(16'(ale_n), 16'd1);
    chk(ale_a, 16'h1000);
    rd(16'h1000);
    chk(mem_rdata, 16'h00A5);
    rd(16'h0FFF);
    chk(16'(strb), 16'd0);
    io(IO_MCU_CTL, 8'hC0);
    wr(16'h1001, 8'h5C);
    chk(16'(n), 16'd4);
    $display("external test done");
  endtask

  task automatic t_stack();
    io(IO_MCU_CTL, 8'h00);
    mem(1'b1, AM_PUSH, PTR_X, 6'h00, 16'h0000, 8'h00, 1'b1);
    chk(16'(n), 16'd3);
    chk(stack_ptr, 16'h01FE);
    rd(16'h0200);
    chk(mem_rdata, 16'h0034);
    rd(16'h01FF);
    chk(mem_rdata, 16'h0012);
    mem(1'b0, AM_POP, PTR_X, 6'h00, 16'h0000, 8'h00, 1'b1);
    chk(ret_pc, 16'h1234);
    io(IO_MCU_CTL, 8'h80);
    io(IO_SP_HI, 8'h20);
    mem(1'b1, AM_PUSH, PTR_X, 6'h00, 16'h0000, 8'h00, 1'b1);
    chk(16'(n), 16'd5);
    $display("stack test done");
  endtask

  task automatic t_misc();
    @(posedge core_clk);
    irq_pend <= 8'hA4;
    pc_load <= 1'b1;
    pc_value <= 16'h0100;
    @(posedge core_clk);
    pc_load <= 1'b0;
    fetch_adv <= 1'b1;
    instr_word <= 16'hABCD;
    @(posedge core_clk);
    fetch_adv <= 1'b0;
    #1;
    chk(program_counter, 16'h0101);
    chk(instr, 16'hABCD);
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(irq_grant), 16'h0004);
    chk(16'(irq_vec), 16'h0002);
    $display("fetch and irq test done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk({14'h0000, ext_bus.rd_n, ext_bus.wr_n}, 16'h0003);
    chk(program_counter, 16'h0000);
    t_alu();
    t_map();
    t_ptr();
    t_ext();
    t_stack();
    t_misc();
    end_of_test();
  end

  initial begin
    #100000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule

`default_nettype wire

// ==== ext_sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ext_sram_model
  import data_map_pkg::*;
(
  input  wire logic     core_clk,
  input  wire ext_bus_s ext_bus,
  output logic [7:0]    dq
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_q;
  logic [7:0]  last_q = 8'hA5;
  logic [15:0] ea;

  // ----------------------------------------------------------------
  // address latch and array
  // ----------------------------------------------------------------
  always_latch begin
    if (ext_bus.ale) begin
      lat_q <= ext_bus.ad_out;
    end
  end
  assign ea = {ext_bus.addr_hi, lat_q};

  // sampling on the clock avoids racing the strobe release against the data change
  always_ff @(posedge core_clk) begin
    if (!ext_bus.wr_n) begin
      mem[ea] <= ext_bus.ad_out;
    end
    if (!ext_bus.rd_n) begin
      last_q <= mem[ea];
    end
  end
  // released pins show the inverse of the last byte, never a stale copy
  assign dq = !ext_bus.rd_n ? mem[ea] : ~last_q;
endmodule

`default_nettype wire

// ==== pin_sync3.sv ====
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // a change is taken only once the second and third stages agree
  always_comb begin
    s_d    = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.o = s_q.s3;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.o;

endmodule

`default_nettype wire
